// ===== rscap_pkg.sv
// shared constants and carrier types for the register state capture block
`default_nettype none
package rscap_pkg;
    localparam int unsigned WORD_W            = 32;
    localparam int unsigned ADDR_W            = 8;

    typedef logic [ADDR_W-1:0] rscap_addr_type;
    typedef logic [WORD_W-1:0] rscap_word_type;

    // register byte addresses
    localparam rscap_addr_type OFS_CMD        = 8'h00;
    localparam rscap_addr_type OFS_CTRL       = 8'h04;
    localparam rscap_addr_type OFS_STATUS     = 8'h08;
    localparam rscap_addr_type OFS_RDBK       = 8'h0c;
    localparam rscap_addr_type OFS_INIT_INDEX = 8'h10;
    localparam rscap_addr_type OFS_INIT_DATA  = 8'h14;

    // command codes written to the command register
    localparam logic [3:0] CMD_NULL           = 4'h0;
    localparam logic [3:0] CMD_RDBK_START     = 4'h4;
    localparam logic [3:0] CMD_RESTORE        = 4'ha;
    localparam logic [3:0] CMD_CAPTURE        = 4'hc;
    localparam int unsigned CMD_W             = 4;

    // control register fields
    localparam int unsigned CTRL_SINGLE_CAPTURE_OPTION_BIT  = 0;
    localparam int unsigned CTRL_TCK_SEL_BIT  = 1;
    localparam int unsigned CTRL_W            = 2;
    localparam logic [1:0] CTRL_RESET         = 2'h0;

    // status register fields
    localparam int unsigned STAT_STROBE_BIT   = 0;
    localparam int unsigned STAT_HOLD_BIT     = 1;
    localparam int unsigned STAT_ARMED_BIT    = 2;
    localparam int unsigned STAT_PAD_BIT      = 3;
    localparam int unsigned STAT_DONE_BIT     = 4;

    // strobe length after a capture command, in startup clock cycles
    localparam int unsigned STROBE_CYCLES     = 2;
    localparam int unsigned HOLD_CNT_W        = 2;

    // defaults of the structural parameters
    localparam int unsigned DEF_STATE_BITS    = 64;
    localparam int unsigned DEF_FRAME_WORDS   = 2;

    typedef struct packed {
        rscap_addr_type addr;
        rscap_word_type wdata;
        logic           wr;
        logic           rd;
    } rscap_bus_req_type;

    typedef enum logic [0:0] {
        CAP_IDLE,
        CAP_CMD_HOLD
    } rscap_cap_state_type;
endpackage : rscap_pkg
`default_nettype wire

// ===== rscap_readback.sv
// readback word sequencer: one pad frame, then the capture cells word by word
`default_nettype none
module rscap_readback
#(
    parameter int unsigned STATE_BITS  = rscap_pkg::DEF_STATE_BITS,
    parameter int unsigned FRAME_WORDS = rscap_pkg::DEF_FRAME_WORDS
)
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire logic                  start,
    input  wire logic                  advance,
    input  wire logic [STATE_BITS-1:0] cells,
    output rscap_pkg::rscap_word_type  word,
    output logic                       in_pad,
    output logic                       done
);
    import rscap_pkg::*;

    localparam int unsigned DATA_WORDS = STATE_BITS / WORD_W;
    localparam int unsigned TOTAL      = FRAME_WORDS + DATA_WORDS;
    localparam int unsigned PTR_W      = $clog2(TOTAL + 1);

    logic [PTR_W-1:0] ptr_r;
    logic [PTR_W-1:0] ptr_nxt;
    int unsigned      idx;

    always_comb
    begin
        ptr_nxt = ptr_r;
        if (start)
            ptr_nxt = '0;
        else if (advance && !done)
            ptr_nxt = ptr_r + PTR_W'(1);
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            ptr_r <= '0;
        else
            ptr_r <= ptr_nxt;
    end

    // pad words and reads past the end return zero; no header, no crc
    always_comb
    begin
        idx  = 0;
        word = '0;
        if (!in_pad && !done)
        begin
            idx  = int'(ptr_r) - FRAME_WORDS;
            word = cells[idx*WORD_W +: WORD_W]; // see [R11] see [R8]
        end
    end

    assign in_pad = (int'(ptr_r) < FRAME_WORDS); // see [R11]
    assign done   = (int'(ptr_r) >= TOTAL);
endmodule : rscap_readback
`default_nettype wire

// ===== rscap_sync.sv
// two-flop synchroniser for a group of asynchronous pins
`default_nettype none
module rscap_sync
#(
    parameter int unsigned W = 1
)
(
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import rscap_pkg::*;

    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb
    begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_r <= '0;
            q_r    <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r    <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : rscap_sync
`default_nettype wire

// ===== rscap_top.sv
// register state capture: capture strobe, capture cells, restore and readback
//
// Implementation choices: the placing of the registers and the plain strobed port.
`default_nettype none

// Notes on behaviour
// [R1] request high at a capture clock rising edge raises the capture strobe.
// [R2] controller reads capture data with the normal readback sequence after sampling.
// [R3] captured value lands in the cell holding that register's initial state.
// [R4] capture command holds the strobe two configuration or test clock cycles.
// [R5] request held high captures again on every capture clock rising edge.
// [R6] single capture option captures only on the first edge of a request.
// [R7] restore loads every register from its cell; command or startup block.
// [R8] captured values come out with the normal configuration readback.
// [R9] controller locates bits by stream offset, frame address and frame offset.
// [R10] cells hold captured state inverted; readers complement the bits.
// [R11] readback gives one pad frame then frame data, no headers, no crc.
// [R12] single capture re-arms after the request is seen low at an edge.
module rscap_top
#(
    parameter int unsigned STATE_BITS  = rscap_pkg::DEF_STATE_BITS,
    parameter int unsigned FRAME_WORDS = rscap_pkg::DEF_FRAME_WORDS
)
(
    input  wire logic                        ref_clk,
    input  wire logic                        rst_b,
    input  wire rscap_pkg::rscap_bus_req_type bus_req,
    output rscap_pkg::rscap_word_type        rd_data,
    input  wire logic                        capture_clock,
    input  wire logic                        capture_request,
    input  wire logic                        configuration_clock,
    input  wire logic                        test_clock,
    input  wire logic                        startup_restore,
    input  wire logic [STATE_BITS-1:0]       live_state,
    output logic                             capture_strobe,
    output logic                             restore_strobe,
    output logic      [STATE_BITS-1:0]       restore_data
);
    import rscap_pkg::*;

    localparam int unsigned DATA_WORDS = STATE_BITS / WORD_W;
    localparam int unsigned IDX_W      = (DATA_WORDS > 1) ? $clog2(DATA_WORDS) : 1;

    // pin synchronisers: capture clock, request, configuration clock, test clock
    logic [3:0] pins_sync;
    logic       cap_clk_s;
    logic       cap_req_s;
    logic       cfg_clk_s;
    logic       tst_clk_s;

    rscap_sync #(
        .W (4)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .d       ({capture_clock, capture_request, configuration_clock, test_clock}),
        .q       (pins_sync)
    );

    assign cap_clk_s = pins_sync[3];
    assign cap_req_s = pins_sync[2];
    assign cfg_clk_s = pins_sync[1];
    assign tst_clk_s = pins_sync[0];

    // bus decode
    function automatic logic hit(input rscap_addr_type a, input rscap_addr_type ofs);
        hit = (a == ofs);
    endfunction : hit

    logic wr_cmd;
    logic wr_ctrl;
    logic wr_idx;
    logic wr_init;
    logic rd_rdbk;
    logic cmd_capture;
    logic cmd_restore;
    logic cmd_rdbk_start;

    assign wr_cmd         = bus_req.wr && hit(bus_req.addr, OFS_CMD);
    assign wr_ctrl        = bus_req.wr && hit(bus_req.addr, OFS_CTRL);
    assign wr_idx         = bus_req.wr && hit(bus_req.addr, OFS_INIT_INDEX);
    assign wr_init        = bus_req.wr && hit(bus_req.addr, OFS_INIT_DATA);
    assign rd_rdbk        = bus_req.rd && hit(bus_req.addr, OFS_RDBK);
    assign cmd_capture    = wr_cmd && (bus_req.wdata[CMD_W-1:0] == CMD_CAPTURE);
    assign cmd_restore    = wr_cmd && (bus_req.wdata[CMD_W-1:0] == CMD_RESTORE);
    assign cmd_rdbk_start = wr_cmd && (bus_req.wdata[CMD_W-1:0] == CMD_RDBK_START);

    // control and init index registers
    logic [CTRL_W-1:0] ctrl_r;
    logic [CTRL_W-1:0] ctrl_nxt;
    logic [IDX_W-1:0]  init_idx_r;
    logic [IDX_W-1:0]  init_idx_nxt;
    logic              single_capture_option;
    logic              tck_sel;

    always_comb
    begin
        ctrl_nxt     = ctrl_r;
        init_idx_nxt = init_idx_r;
        if (wr_ctrl)
            ctrl_nxt = bus_req.wdata[CTRL_W-1:0];
        if (wr_idx)
            init_idx_nxt = bus_req.wdata[IDX_W-1:0];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_r     <= CTRL_RESET;
            init_idx_r <= '0;
        end
        else
        begin
            ctrl_r     <= ctrl_nxt;
            init_idx_r <= init_idx_nxt;
        end
    end

    assign single_capture_option = ctrl_r[CTRL_SINGLE_CAPTURE_OPTION_BIT];
    assign tck_sel = ctrl_r[CTRL_TCK_SEL_BIT];

    // edge detection on the synchronised clocks
    logic cap_clk_d_r;
    logic cfg_clk_d_r;
    logic tst_clk_d_r;
    logic cap_edge;
    logic start_edge;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_clk_d_r <= 1'b0;
            cfg_clk_d_r <= 1'b0;
            tst_clk_d_r <= 1'b0;
        end
        else
        begin
            cap_clk_d_r <= cap_clk_s;
            cfg_clk_d_r <= cfg_clk_s;
            tst_clk_d_r <= tst_clk_s;
        end
    end

    assign cap_edge   = cap_clk_s && !cap_clk_d_r;
    // startup clock choice picks which clock paces the command strobe
    assign start_edge = tck_sel ? (tst_clk_s && !tst_clk_d_r)
                                : (cfg_clk_s && !cfg_clk_d_r);

    // user capture path with single capture arming
    logic armed_r;
    logic armed_nxt;
    logic pin_fire;

    // without the single capture option every edge with the request high fires
    assign pin_fire = cap_edge && cap_req_s && (!single_capture_option || armed_r); // see [R1] see [R5] see [R6]

    always_comb
    begin
        armed_nxt = armed_r;
        if (cap_edge)
        begin
            if (!cap_req_s)
                armed_nxt = 1'b1; // see [R12]
            else if (single_capture_option)
                armed_nxt = 1'b0; // see [R6]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            armed_r <= 1'b1;
        else
            armed_r <= armed_nxt;
    end

    // command capture: strobe held for a fixed count of startup clock edges
    rscap_cap_state_type       state_r;
    rscap_cap_state_type       state_nxt;
    logic [HOLD_CNT_W-1:0]     hold_cnt_r;
    logic [HOLD_CNT_W-1:0]     hold_cnt_nxt;
    logic                      strobe_r;
    logic                      strobe_nxt;

    always_comb
    begin
        state_nxt    = state_r;
        hold_cnt_nxt = hold_cnt_r;
        unique case (state_r)
            CAP_IDLE:
            begin
                if (cmd_capture)
                begin
                    state_nxt    = CAP_CMD_HOLD;
                    hold_cnt_nxt = '0;
                end
            end
            CAP_CMD_HOLD:
            begin
                if (start_edge)
                begin
                    if (hold_cnt_r == HOLD_CNT_W'(STROBE_CYCLES - 1))
                        state_nxt = CAP_IDLE; // see [R4]
                    else
                        hold_cnt_nxt = hold_cnt_r + HOLD_CNT_W'(1);
                end
            end
        endcase
        strobe_nxt = pin_fire || (state_nxt == CAP_CMD_HOLD); // see [R4] see [R1]
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r    <= CAP_IDLE;
            hold_cnt_r <= '0;
            strobe_r   <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            hold_cnt_r <= hold_cnt_nxt;
            strobe_r   <= strobe_nxt;
        end
    end

    assign capture_strobe = strobe_r;

    // capture cells: init state and captured state share one inverted cell
    logic [STATE_BITS-1:0] cells_r;
    logic [STATE_BITS-1:0] cells_nxt;

    always_comb
    begin
        cells_nxt = cells_r;
        if (wr_init)
            cells_nxt[init_idx_r*WORD_W +: WORD_W] = ~bus_req.wdata; // see [R10]
        // a capture in the same cycle wins over a configuration word write
        if (strobe_r)
            cells_nxt = ~live_state; // see [R3] see [R10] see [R5]
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            cells_r <= '1;
        else
            cells_r <= cells_nxt;
    end

    // restore: after a capture this brings back the captured, not configured, state
    logic                  restore_r;
    logic                  restore_nxt;
    logic [STATE_BITS-1:0] restore_data_r;
    logic [STATE_BITS-1:0] restore_data_nxt;

    always_comb
    begin
        restore_nxt      = cmd_restore || startup_restore; // see [R7]
        restore_data_nxt = restore_data_r;
        if (restore_nxt)
            restore_data_nxt = ~cells_r; // see [R7] see [R3]
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            restore_r      <= 1'b0;
            restore_data_r <= '0;
        end
        else
        begin
            restore_r      <= restore_nxt;
            restore_data_r <= restore_data_nxt;
        end
    end

    assign restore_strobe = restore_r;
    assign restore_data   = restore_data_r;

    // readback stream; controller finds captured bits by offset
    rscap_word_type rb_word;
    logic           rb_pad;
    logic           rb_done;

    rscap_readback #(
        .STATE_BITS  (STATE_BITS),
        .FRAME_WORDS (FRAME_WORDS)
    ) u_readback (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .start   (cmd_rdbk_start),
        .advance (rd_rdbk), // see [R8]
        .cells   (cells_r),
        .word    (rb_word),
        .in_pad  (rb_pad),
        .done    (rb_done)
    );

    // read data, valid only in the cycle after the read strobe
    rscap_word_type rd_data_r;
    rscap_word_type rd_data_nxt;
    rscap_word_type status;

    always_comb
    begin
        status                  = '0;
        status[STAT_STROBE_BIT] = strobe_r;
        status[STAT_HOLD_BIT]   = (state_r == CAP_CMD_HOLD);
        status[STAT_ARMED_BIT]  = armed_r;
        status[STAT_PAD_BIT]    = rb_pad;
        status[STAT_DONE_BIT]   = rb_done;
        rd_data_nxt             = '0;
        if (bus_req.rd)
        begin
            if (hit(bus_req.addr, OFS_CTRL))
                rd_data_nxt = WORD_W'(ctrl_r);
            else if (hit(bus_req.addr, OFS_STATUS))
                rd_data_nxt = status;
            else if (hit(bus_req.addr, OFS_RDBK))
                rd_data_nxt = rb_word; // see [R11]
            else if (hit(bus_req.addr, OFS_INIT_INDEX))
                rd_data_nxt = WORD_W'(init_idx_r);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rd_data_r <= '0;
        else
            rd_data_r <= rd_data_nxt;
    end

    assign rd_data = rd_data_r;
endmodule : rscap_top
`default_nettype wire

// ===== rscap_top_properties.sv
// concurrent checks on the capture block ports
`default_nettype none
module rscap_top_properties
#(
    parameter int unsigned STATE_BITS  = rscap_pkg::DEF_STATE_BITS,
    parameter int unsigned FRAME_WORDS = rscap_pkg::DEF_FRAME_WORDS
)
(
    input wire logic                         ref_clk,
    input wire logic                         rst_b,
    input wire rscap_pkg::rscap_bus_req_type bus_req,
    input wire rscap_pkg::rscap_word_type    rd_data,
    input wire logic                         capture_clock,
    input wire logic                         capture_request,
    input wire logic                         configuration_clock,
    input wire logic                         test_clock,
    input wire logic                         startup_restore,
    input wire logic [STATE_BITS-1:0]        live_state,
    input wire logic                         capture_strobe,
    input wire logic                         restore_strobe,
    input wire logic [STATE_BITS-1:0]        restore_data
);
    import rscap_pkg::*;
    logic [2:0] cc_r;
    logic [2:0] cf_r;
    logic [2:0] tk_r;
    logic [1:0] rq_r;
    logic       one_r;
    logic       tsel_r;
    logic       armed_r;
    logic       hold_r;
    logic       hcnt_r;
    logic [7:0] idx_r;
    logic [STATE_BITS-1:0] cells_r;
    // local copy of the two-flop sync so edges line up with the design's view
    wire logic cap_edge = cc_r[1] & ~cc_r[2];
    wire logic st_edge  = tsel_r ? (tk_r[1] & ~tk_r[2]) : (cf_r[1] & ~cf_r[2]);
    wire logic pin_cap  = cap_edge & rq_r[1] & (armed_r | ~one_r);
    wire logic wr_cmd   = bus_req.wr && bus_req.addr == OFS_CMD;
    wire logic cmd_cap  = wr_cmd && bus_req.wdata[3:0] == CMD_CAPTURE;
    wire logic rs_req   = startup_restore | (wr_cmd && bus_req.wdata[3:0] == CMD_RESTORE);
    wire logic rd_zero  = bus_req.addr == OFS_CMD || bus_req.addr == OFS_INIT_DATA
                          || bus_req.addr > OFS_INIT_DATA;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {cc_r, cf_r, tk_r, rq_r} <= '0;
            {one_r, tsel_r, hold_r, hcnt_r} <= '0;
            armed_r <= 1'b1;
            idx_r   <= 8'h00;
            cells_r <= '1;
        end
        else
        begin
            cc_r <= {cc_r[1:0], capture_clock};
            cf_r <= {cf_r[1:0], configuration_clock};
            tk_r <= {tk_r[1:0], test_clock};
            rq_r <= {rq_r[0], capture_request};
            if (bus_req.wr && bus_req.addr == OFS_CTRL)
                {tsel_r, one_r} <= bus_req.wdata[1:0];
            if (bus_req.wr && bus_req.addr == OFS_INIT_INDEX)
                idx_r <= bus_req.wdata[7:0];
            if (cap_edge && !rq_r[1])
                armed_r <= 1'b1;
            else if (cap_edge && one_r)
                armed_r <= 1'b0;
            if (!hold_r && cmd_cap)
                {hold_r, hcnt_r} <= 2'b10;
            else if (hold_r && st_edge)
                {hold_r, hcnt_r} <= {~hcnt_r, 1'b1};
            if (capture_strobe)
                cells_r <= ~live_state;
            else if (bus_req.wr && bus_req.addr == OFS_INIT_DATA)
                cells_r[idx_r*32 +: 32] <= ~bus_req.wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_pulse;
        capture_strobe ##1 !capture_strobe;
    endsequence
    sequence s_hold;
        capture_strobe[*2] ##[1:40] !capture_strobe;
    endsequence
    a_pin_capture: assert property (pin_cap && !hold_r && !cmd_cap
        |=> s_pulse)
        else $error("pin capture strobe wrong");
    a_strobe_cause: assert property ($rose(capture_strobe)
        |-> $past(pin_cap || cmd_cap))
        else $error("strobe without cause");
    a_cmd_hold: assert property (cmd_cap && !hold_r |=> s_hold)
        else $error("command strobe length wrong");
    a_hold_level: assert property (hold_r |-> capture_strobe)
        else $error("strobe dropped during hold");
    a_hold_release: assert property ($fell(hold_r) && !$past(pin_cap)
        |-> !capture_strobe)
        else $error("strobe held too long");
    a_single_capture_option_skip: assert property (cap_edge && rq_r[1] && one_r
        && !armed_r && !hold_r && !cmd_cap |=> !capture_strobe)
        else $error("single capture repeated");
    a_restore_data: assert property (rs_req |=> restore_strobe
        && restore_data == ~$past(cells_r))
        else $error("restore data wrong");
    a_restore_idle: assert property (!rs_req |=> !restore_strobe)
        else $error("restore without request");
    a_read_idle: assert property (!bus_req.rd |=> rd_data == '0)
        else $error("read data outside read");
    a_read_zero: assert property (bus_req.rd && rd_zero |=> rd_data == '0)
        else $error("unreadable place gave data");
endmodule : rscap_top_properties
bind rscap_top rscap_top_properties #(.STATE_BITS(STATE_BITS), .FRAME_WORDS(FRAME_WORDS))
    u_props (.ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .capture_clock(capture_clock), .capture_request(capture_request),
    .configuration_clock(configuration_clock), .test_clock(test_clock),
    .startup_restore(startup_restore), .live_state(live_state),
    .capture_strobe(capture_strobe), .restore_strobe(restore_strobe),
    .restore_data(restore_data));
`default_nettype wire

// ===== rscap_top_test.sv
// self-checking bench for the register state capture block
`default_nettype none
module rscap_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    import rscap_pkg::*;
    localparam int SB = 64;
    localparam int FRAME_WORDS_T = 2;
    logic ref_clk;
    logic rst_b;
    rscap_bus_req_type bus_req;
    rscap_word_type rd_data;
    logic capture_clock;
    logic capture_request;
    logic configuration_clock;
    logic test_clock;
    logic startup_restore;
    logic fire;
    logic rd_late;
    logic capture_strobe;
    logic restore_strobe;
    logic [SB-1:0] live_state;
    logic [SB-1:0] restore_data;
    logic [SB-1:0] a;
    logic [SB-1:0] b;
    logic [SB-1:0] rd_q[$];
    logic [SB-1:0] rs_q[$];
    int fails;
    int comparisons;
    int sel;
    rscap_top #(.STATE_BITS(SB), .FRAME_WORDS(FRAME_WORDS_T)) dut (.ref_clk(ref_clk),
        .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data), .capture_clock(capture_clock),
        .capture_request(capture_request), .configuration_clock(configuration_clock),
        .test_clock(test_clock), .startup_restore(startup_restore), .live_state(live_state),
        .capture_strobe(capture_strobe), .restore_strobe(restore_strobe),
        .restore_data(restore_data));
    rscap_user_model far (.ref_clk(ref_clk), .rst_b(rst_b), .fire(fire),
        .capture_clock(capture_clock), .configuration_clock(configuration_clock),
        .test_clock(test_clock));
    task automatic chk(input logic [SB-1:0] got, input logic [SB-1:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim
    // strobes are lowered a full cycle before the next request can raise them
    task automatic wr(input rscap_addr_type ad, input rscap_word_type d);
        {bus_req.addr, bus_req.wdata, bus_req.wr} <= {ad, d, 1'b1};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input rscap_addr_type ad, input rscap_word_type exp);
        rd_q.push_back(SB'(exp));
        {bus_req.addr, bus_req.rd} <= {ad, 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task automatic cap(input logic req, input logic [SB-1:0] st);
        capture_request <= req;
        live_state      <= st;
        @(posedge ref_clk);
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (15) @(posedge ref_clk);
    endtask : cap
    task automatic restore(input logic [SB-1:0] exp, input logic startup);
        rs_q.push_back(exp);
        if (startup)
        begin
            startup_restore <= 1'b1;
            @(posedge ref_clk);
            startup_restore <= 1'b0;
            @(posedge ref_clk);
        end
        else
            wr(OFS_CMD, {28'h0, CMD_RESTORE});
    endtask : restore
    // pad frame first, then capture words in inverted sense, then zeros once done
    task automatic readback(input logic [SB-1:0] exp);
        wr(OFS_CMD, {28'h0, CMD_RDBK_START});
        repeat (FRAME_WORDS_T) rd(OFS_RDBK, 32'h0);
        for (int k = 0; k < SB / 32; k++)
            rd(OFS_RDBK, ~exp[k*32 +: 32]);
        rd(OFS_RDBK, 32'h0);
    endtask : readback
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        rd_late <= bus_req.rd;
    always @(negedge ref_clk)
    begin
        if (rd_late === 1'b1)
            chk(SB'(rd_data), rd_q.pop_front());
        if (restore_strobe === 1'b1)
            chk(restore_data, rs_q.pop_front());
    end
    initial
    begin
        #(40 * 5000);
        fails++;
        $display("BAD %0t run did not finish", $time);
        end_sim();
    end
    initial
    begin
        {rst_b, bus_req, capture_request, startup_restore, fire} = '0;
        {fails, comparisons} = '0;
        live_state = '0;
        sel = $urandom(2);
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rd(OFS_CTRL, 32'h0);
        rd(8'h40, 32'h0);
        rd(OFS_CMD, 32'h0);
        rd(OFS_STATUS, 32'(1 << STAT_ARMED_BIT | 1 << STAT_PAD_BIT));
        restore('0, 1'b1);
        a = {$urandom, $urandom};
        cap(1'b1, a);
        cap(1'b0, ~a);
        restore(a, 1'b0);
        readback(a);
        a = {$urandom, $urandom};
        b = {$urandom, $urandom};
        cap(1'b1, a);
        cap(1'b1, b);
        restore(b, 1'b0);
        cap(1'b0, a);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_CTRL, 32'h1);
        cap(1'b1, a);
        cap(1'b1, b);
        restore(a, 1'b0);
        cap(1'b0, b);
        cap(1'b1, b);
        restore(b, 1'b1);
        cap(1'b0, a);
        for (sel = 0; sel < 2; sel++)
        begin
            wr(OFS_CTRL, 32'(sel * 2));
            a = {$urandom, $urandom};
            live_state <= a;
            wr(OFS_CMD, {28'h0, CMD_CAPTURE});
            repeat (40) @(posedge ref_clk);
            restore(a, 1'b0);
        end
        b = {$urandom, $urandom};
        wr(OFS_INIT_INDEX, 32'h1);
        rd(OFS_INIT_INDEX, 32'h1);
        wr(OFS_INIT_DATA, b[31:0]);
        restore({b[31:0], a[31:0]}, 1'b1);
        readback({b[31:0], a[31:0]});
        rd(OFS_STATUS, 32'(1 << STAT_ARMED_BIT | 1 << STAT_DONE_BIT));
        repeat (4) @(posedge ref_clk);
        end_sim();
    end
endmodule : rscap_top_test
`default_nettype wire

// ===== rscap_user_model.sv
// far-side model: user capture clock pulses and the two startup clocks
`default_nettype none
module rscap_user_model
(
    input  wire logic ref_clk,
    input  wire logic rst_b,
    input  wire logic fire,
    output logic      capture_clock,
    output logic      configuration_clock,
    output logic      test_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cap_cnt_r;
    logic [2:0] cfg_cnt_r;
    logic [2:0] tck_cnt_r;
    logic       cfg_r;
    logic       tck_r;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_cnt_r <= 4'h0;
            cfg_cnt_r <= 3'h0;
            tck_cnt_r <= 3'h0;
            cfg_r     <= 1'b0;
            tck_r     <= 1'b0;
        end
        else
        begin
            if (fire && cap_cnt_r == 4'h0)
                cap_cnt_r <= 4'h8;
            else if (cap_cnt_r != 4'h0)
                cap_cnt_r <= cap_cnt_r - 4'h1;
            cfg_cnt_r <= (cfg_cnt_r == 3'h2) ? 3'h0 : cfg_cnt_r + 3'h1;
            tck_cnt_r <= (tck_cnt_r == 3'h4) ? 3'h0 : tck_cnt_r + 3'h1;
            if (cfg_cnt_r == 3'h2)
                cfg_r <= ~cfg_r;
            if (tck_cnt_r == 3'h4)
                tck_r <= ~tck_r;
        end
    end
    // capture clock stands low between pulses; 4 cycles high keeps it slow enough to sync
    assign capture_clock       = cap_cnt_r > 4'h4;
    assign configuration_clock = cfg_r;
    assign test_clock          = tck_r;
endmodule : rscap_user_model
`default_nettype wire
